// ---- hw/vocoder_stream_transfer.v ----
// streaming data transfer between host serial bus and vocoder core:
// streaming registers, one-packet buffers, ready flags, errors.
// assumes serial bus pins come from another clock domain; analogue
// sample input is on sys_clk.
//
// Function
// - coded registers carry one byte per access, sample registers sixteen bits.
// - each streaming register holds one packet of frames sized by codec_config; in pass mode one packet is 16 words.
// - streaming registers accept single or burst accesses on the host bus.
// - only one input and one output streaming register in use at a time.
// - input register copied into one-packet input buffer; output buffer feeds output.
// - reset and mode entry leave both buffers empty, room for two packets.
// - full two-packet storage halts processing and flags data overflow.
// - decoding starts on a full packet, output given after whole packet.
// - encoding starts as soon as one frame of input has arrived.
// - encoding presents output with output_ready_flag only after whole packet.
// - encoding sets input_wanted_flag when the last frame starts processing.
// - any mode_control write flushes all streaming registers and buffers.
// - analogue source only in encode, encode-decode, pass; fills buffer itself.
// - analogue input at 8 kHz; slow host reads cause overflow flag.
// - processed packet loaded to output register with output_ready_flag set.
// - analogue destination only in decode, encode-decode, pass; drains buffer.
// - bus input to analogue output at 8 kHz; slow writes flag underflow.
// - output gate mutes quiet output, decode and encode-decode only.
// - mode_control selects one of six modes.
// - idle_programming writes take effect only in idle mode.
// - packets are one, two, three or four frames.
// - output_ready_flag is status bit 3, input_wanted_flag bit 4.
`timescale 1ns/1ps
`default_nettype none
`include "vocoder_stream_defs.vh"

module vocoder_stream_transfer #(
   parameter SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS,
   parameter PROC_CYCLES   = `FRAME_PROC_CYCLES
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        ce,
   input  wire        busSelN,
   input  wire        busClk,
   input  wire        busDataIn,
   output reg         busDataOut,
   input  wire [15:0] analogIn,
   output reg  [15:0] audioOut,
   output reg  [15:0] noiseLevel,
   output reg  [15:0] biasCtrl,
   output reg  [15:0] progValue
);

   // ====================================================
   // helpers
   function [9:0] frameWords;
      input sample;
      input pass;
      begin
         if (pass)
            frameWords = `PASS_PACKET_WORDS;
         else if (sample)
            frameWords = `SAMPLES_PER_FRAME;
         else
            frameWords = `BYTES_PER_FRAME;
      end
   endfunction

   function [15:0] replyWord;
      input [7:0]  a;
      input [15:0] ov;
      input [15:0] st;
      begin
         case (a)
            `ADDR_CODED_OUT:  replyWord = {ov[7:0], 8'h00};
            `ADDR_SAMPLE_OUT: replyWord = ov;
            `ADDR_STATUS:     replyWord = st;
            default:          replyWord = 16'h0000;
         endcase
      end
   endfunction

   function isByteReg;
      input [7:0] a;
      begin
         isByteReg = (a == `ADDR_CODED_IN) || (a == `ADDR_CODED_OUT);
      end
   endfunction

   // ====================================================
   // serial pin synchronisers
   reg        selS1, selS2, clkS1, clkS2, clkS3, dinS1, dinS2;
   reg [15:0] shiftIn;
   reg [15:0] shiftOut;
   reg [4:0]  bitCnt;
   reg [7:0]  addr;
   reg        haveAddr;
   reg        wrEn;
   reg [7:0]  wrAddr;
   reg [15:0] wrData;
   reg        rdPop;
   wire       clkRise = clkS2 & ~clkS3;
   wire       clkFall = ~clkS2 & clkS3;
   wire [4:0] lastBit = isByteReg(addr) ? 5'h07 : 5'h0F;

   // ====================================================
   // core state
   reg [15:0] mode, codecCfg, routing, gateCfg, lastIn, playSample;
   reg [9:0]  inHeld, inBufCnt, outRegCnt, outIdx;
   reg        outBufFull, outputReadyFlag, inputWantedFlag, overflow, underflow, halted;
   reg        procBusy, playStarted, muted;
   reg [1:0]  procFrame;
   reg [7:0]  procTimer;
   reg [12:0] tickCnt;
   reg [2:0]  quietCnt;

   wire [2:0] md = mode[2:0];
   wire active = (md != `MODE_IDLE);
   wire pass = (md == `MODE_PASS);
   // the mode picks which of each register pair is live
   wire inSample = (md == `MODE_ENCODE) || (md == `MODE_ENCDEC) || pass;
   wire outSample = (md == `MODE_DECODE) || (md == `MODE_ENCDEC) || pass;
   wire srcAnalog = inSample && (routing[3:0] != `ROUTE_BUS);
   wire dstAnalog = outSample && (routing[7:4] != `ROUTE_BUS);
   wire [2:0] frames = pass ? 3'h1 :
                       (codecCfg[1:0] == 2'h0) ? 3'h4 : {1'b0, codecCfg[1:0]};
   wire [9:0] fwIn = frameWords(inSample, pass);
   wire [9:0] fwOut = frameWords(outSample, pass);
   wire [9:0] pktIn = fwIn * frames;
   wire [9:0] pktOut = fwOut * frames;
   wire       tick = (tickCnt == 13'h0000);
   wire [15:0] outVal = lastIn ^ {6'h00, outIdx};
   wire [15:0] status = {md, 6'h00, underflow, overflow, inputWantedFlag,
                         outputReadyFlag, 3'h0};
   wire [15:0] absSample = outVal[15] ? (16'h0000 - outVal) : outVal;
   wire [15:0] reply = replyWord(addr, outVal, status);

   // ====================================================
   // serial slave: address byte then streamed data words
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         selS1 <= 1'b1;
         selS2 <= 1'b1;
         clkS1 <= 1'b1;
         clkS2 <= 1'b1;
         clkS3 <= 1'b1;
         dinS1 <= 1'b0;
         dinS2 <= 1'b0;
         shiftIn <= 16'h0000;
         shiftOut <= 16'h0000;
         bitCnt <= 5'h00;
         addr <= 8'h00;
         haveAddr <= 1'b0;
         wrEn <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 16'h0000;
         rdPop <= 1'b0;
         busDataOut <= 1'b0;
      end else if (ce) begin
         selS1 <= busSelN;
         selS2 <= selS1;
         clkS1 <= busClk;
         clkS2 <= clkS1;
         clkS3 <= clkS2;
         dinS1 <= busDataIn;
         dinS2 <= dinS1;
         wrEn <= 1'b0;
         rdPop <= 1'b0;
         if (selS2) begin
            bitCnt <= 5'h00;
            haveAddr <= 1'b0;
         end else if (clkRise) begin
            shiftIn <= {shiftIn[14:0], dinS2};
            if (!haveAddr) begin
               bitCnt <= bitCnt + 5'h01;
               if (bitCnt == 5'h07) begin
                  addr <= {shiftIn[6:0], dinS2};
                  haveAddr <= 1'b1;
                  bitCnt <= 5'h00;
               end
            end else if (bitCnt == lastBit) begin
               // select stays low, so the next word streams to the same register
               bitCnt <= 5'h00;
               wrEn <= 1'b1;
               wrAddr <= addr;
               wrData <= {shiftIn[14:0], dinS2};
               // pop only a word shifted out whole, so a single read loses nothing
               rdPop <= 1'b1;
            end else begin
               bitCnt <= bitCnt + 5'h01;
            end
         end else if (clkFall && haveAddr) begin
            // reply fetched at the first fall of each word, after the previous pop
            if (bitCnt == 5'h00) begin
               busDataOut <= reply[15];
               shiftOut <= {reply[14:0], 1'b0};
            end else begin
               busDataOut <= shiftOut[15];
               shiftOut <= {shiftOut[14:0], 1'b0};
            end
         end
      end
   end

   // ====================================================
   // occupancy arithmetic
   wire hostIn = wrEn && active && !srcAnalog &&
                 ((wrAddr == `ADDR_CODED_IN && !inSample) ||
                  (wrAddr == `ADDR_SAMPLE_IN && inSample));
   wire hostPop = rdPop && !dstAnalog && (outRegCnt != 10'h000) &&
                  ((addr == `ADDR_CODED_OUT && !outSample) ||
                   (addr == `ADDR_SAMPLE_OUT && outSample));
   wire hostOvf = hostIn && (inHeld == pktIn);
   wire moveIn = active && !halted && (inHeld != 10'h000) && (inBufCnt < pktIn);
   wire adcIn = active && !halted && srcAnalog && tick;
   wire adcOvf = adcIn && (inBufCnt >= pktIn);
   wire lastFrame = ({1'b0, procFrame} == frames - 3'h1);
   wire procDone = procBusy && (procTimer == 8'h00);
   wire pktDone = procDone && lastFrame && !outBufFull;
   wire procOvf = procDone && lastFrame && outBufFull;
   wire [9:0] need = inSample ? fwIn * ({1'b0, procFrame} + 10'h001) : pktIn;
   wire procStart = active && !halted && !procBusy && (inBufCnt >= need);
   reg  [9:0] next_inHeld, next_inBufCnt;

   always @* begin
      next_inHeld = inHeld;
      next_inBufCnt = inBufCnt;
      if (hostIn && !hostOvf)
         next_inHeld = next_inHeld + 10'h001;
      if (moveIn) begin
         next_inHeld = next_inHeld - 10'h001;
         next_inBufCnt = next_inBufCnt + 10'h001;
      end
      if (adcIn && !adcOvf)
         next_inBufCnt = next_inBufCnt + 10'h001;
      if (pktDone)
         next_inBufCnt = next_inBufCnt - pktIn;
   end

   // ====================================================
   // transfer core
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode <= `RST_WORD;
         codecCfg <= `RST_CONFIG;
         routing <= `RST_ROUTING;
         gateCfg <= `RST_WORD;
         noiseLevel <= `RST_WORD;
         biasCtrl <= `RST_WORD;
         progValue <= `RST_WORD;
         lastIn <= `RST_WORD;
         inHeld <= 10'h000;
         inBufCnt <= 10'h000;
         outRegCnt <= 10'h000;
         outIdx <= 10'h000;
         outBufFull <= 1'b0;
         outputReadyFlag <= 1'b0;
         inputWantedFlag <= 1'b1;
         overflow <= 1'b0;
         underflow <= 1'b0;
         halted <= 1'b0;
         procBusy <= 1'b0;
         procFrame <= 2'h0;
         procTimer <= 8'h00;
         playStarted <= 1'b0;
         tickCnt <= 13'h0000;
      end else if (ce) begin
         tickCnt <= tick ? SAMPLE_CYCLES[12:0] - 13'h0001 : tickCnt - 13'h0001;
         if (wrEn && wrAddr == `ADDR_MODE_CONTROL) begin
            mode <= wrData;
            inHeld <= 10'h000;
            inBufCnt <= 10'h000;
            outRegCnt <= 10'h000;
            outIdx <= 10'h000;
            outBufFull <= 1'b0;
            outputReadyFlag <= 1'b0;
            inputWantedFlag <= 1'b1;
            overflow <= 1'b0;
            underflow <= 1'b0;
            halted <= 1'b0;
            procBusy <= 1'b0;
            procFrame <= 2'h0;
            playStarted <= 1'b0;
            tickCnt <= SAMPLE_CYCLES[12:0] - 13'h0001;
         end else begin
            if (wrEn) begin
               case (wrAddr)
                  `ADDR_CODEC_CONFIG: codecCfg <= wrData;
                  `ADDR_ROUTING: routing <= wrData;
                  `ADDR_GATE_CONFIG: gateCfg <= wrData;
                  `ADDR_NOISE_LEVEL: noiseLevel <= wrData;
                  `ADDR_BIAS: biasCtrl <= wrData;
                  `ADDR_IDLE_PROG: if (!active) progValue <= wrData;
                  default: ;
               endcase
            end
            inHeld <= next_inHeld;
            inBufCnt <= next_inBufCnt;
            if (hostIn && !hostOvf)
               lastIn <= wrData;
            if (adcIn && !adcOvf)
               lastIn <= analogIn;
            // flag clears first so a same-cycle set wins
            if (hostIn && !hostOvf && inHeld == pktIn - 10'h001)
               inputWantedFlag <= 1'b0;
            if (hostOvf || adcOvf || procOvf) begin
               overflow <= 1'b1;
               halted <= 1'b1;
            end
            // a frame runs for a fixed time standing in for the codec
            if (procStart) begin
               procBusy <= 1'b1;
               procTimer <= PROC_CYCLES[7:0] - 8'h01;
               if (inSample && lastFrame)
                  inputWantedFlag <= 1'b1;
            end else if (procBusy && !halted) begin
               procTimer <= procTimer - 8'h01;
               if (procDone && !procOvf) begin
                  procBusy <= 1'b0;
                  procFrame <= lastFrame ? 2'h0 : procFrame + 2'h1;
               end
            end
            if (pktDone) begin
               outBufFull <= 1'b1;
               playStarted <= 1'b1;
               if (!inSample)
                  inputWantedFlag <= 1'b1;
            end
            // output buffer to register, only once the packet is whole
            if (outBufFull && !dstAnalog && outRegCnt == 10'h000 && !pktDone) begin
               outRegCnt <= pktOut;
               outIdx <= 10'h000;
               outBufFull <= 1'b0;
               outputReadyFlag <= 1'b1;
            end else if (hostPop) begin
               outRegCnt <= outRegCnt - 10'h001;
               outIdx <= outIdx + 10'h001;
               if (outRegCnt == 10'h001)
                  outputReadyFlag <= 1'b0;
            end else if (dstAnalog && tick && active) begin
               if (outBufFull) begin
                  outIdx <= (outIdx == pktOut - 10'h001) ? 10'h000 : outIdx + 10'h001;
                  if (outIdx == pktOut - 10'h001)
                     outBufFull <= 1'b0;
               end else if (playStarted && !srcAnalog) begin
                  underflow <= 1'b1;
               end
            end
         end
      end
   end

   // ====================================================
   // analogue output with quiet gate; the delay counts sample ticks
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         audioOut <= 16'h0000;
         quietCnt <= 3'h0;
         muted <= 1'b0;
         playSample <= 16'h0000;
      end else if (ce) begin
         if (dstAnalog && tick && outBufFull) begin
            playSample <= outVal;
            if (absSample[14:3] < gateCfg[11:0]) begin
               if (quietCnt != gateCfg[14:12])
                  quietCnt <= quietCnt + 3'h1;
               else
                  muted <= 1'b1;
            end else begin
               quietCnt <= 3'h0;
               muted <= 1'b0;
            end
         end
         if (gateCfg[`GATE_EN_BIT] && muted &&
             (md == `MODE_DECODE || md == `MODE_ENCDEC))
            audioOut <= 16'h0000;
         else
            audioOut <= playSample;
      end
   end

endmodule // vocoder_stream_transfer

`default_nettype wire

// ---- include/vocoder_stream_defs.vh ----
// register offsets, field positions, mode codes and timing for the
// vocoder streaming transfer block; definitions only.
`ifndef VOCODER_STREAM_DEFS_VH
`define VOCODER_STREAM_DEFS_VH
// ====================================================
// register offsets (serial bus address byte)
`define ADDR_CODED_IN      8'h48
`define ADDR_SAMPLE_IN     8'h49
`define ADDR_CODED_OUT     8'h4C
`define ADDR_SAMPLE_OUT    8'h4D
`define ADDR_NOISE_LEVEL   8'h53
`define ADDR_CODEC_CONFIG  8'h55
`define ADDR_ROUTING       8'h5D
`define ADDR_GATE_CONFIG   8'h5E
`define ADDR_IDLE_PROG     8'h6A
`define ADDR_MODE_CONTROL  8'h6B
`define ADDR_STATUS        8'h7E
`define ADDR_BIAS          8'hB7
// ====================================================
// mode codes in mode_control[2:0]
`define MODE_IDLE          3'h0
`define MODE_DECODE        3'h1
`define MODE_ENCODE        3'h2
`define MODE_ENCDEC        3'h3
`define MODE_PASS          3'h4
`define MODE_ERR_CORR_LOOP 3'h5
// ====================================================
// field positions
`define CFG_FRAMES_LSB     0
`define ROUTE_SRC_LSB      0
`define ROUTE_DST_LSB      4
`define ROUTE_BUS          4'h1
`define GATE_EN_BIT        15
`define GATE_DELAY_LSB     12
`define STAT_READY_BIT     3
`define STAT_WANTED_BIT    4
`define STAT_OVF_BIT       5
`define STAT_UDF_BIT       6
`define STAT_MODE_LSB      13
// ====================================================
// reset values
`define RST_WORD           16'h0000
`define RST_ROUTING        16'h0011
`define RST_CONFIG         16'h0001
// ====================================================
// packet geometry and timing
`define SAMPLES_PER_FRAME  10'h0A0
`define BYTES_PER_FRAME    10'h009
`define PASS_PACKET_WORDS  10'h010
`define CLK_PERIOD_NS      25
`define SAMPLE_PERIOD_NS   125000
`define FRAME_PROC_CYCLES  64
`endif

// ---- tb/host_serial_model.sv ----
// host side of the serial control bus: select, clock and data out,
// reply in. assumes callers enter its task just after a falling sys_clk.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   input  wire logic sys_clk,
   output logic      busSelN,
   output logic      busClk,
   output logic      busDataIn,
   input  wire logic busDataOut
);
   initial begin
      busSelN   = 1'b1;
      busClk    = 1'b1;
      busDataIn = 1'b0;
   end
   // ==========================================
   // one bit per 200 ns clock, data changed on the fall, reply taken late in high
   task automatic shift(input logic [15:0] v, input int n, inout logic [15:0] r);
      for (int i = 0; i < n; i++) begin
         busClk    <= 1'b0;
         busDataIn <= v[15 - i];
         repeat (4) @(negedge sys_clk);
         busClk <= 1'b1;
         repeat (4) @(negedge sys_clk);
         r = {r[14:0], busDataOut};
      end
   endtask
   // address then cnt units of n bits, unit k carrying d + k; r ends with last reply
   task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int n, cnt,
                       output logic [15:0] r);
      logic [15:0] w;
      r = 16'h0000;
      @(negedge sys_clk);
      busSelN <= 1'b0;
      repeat (4) @(negedge sys_clk);
      shift({a, 8'h00}, 8, r);
      for (int k = 0; k < cnt; k++) begin
         w = d + k[15:0];
         shift(w << (16 - n), n, r);
      end
      repeat (4) @(negedge sys_clk);
      busSelN <= 1'b1;
      // released line shows the inverse, never a stale copy
      busDataIn <= ~busDataIn;
      repeat (8) @(negedge sys_clk);
   endtask
endmodule // host_serial_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the vocoder streaming block through its serial bus.
// assumes the host model's task timing and shortened sample and frame counts.
`timescale 1ns/1ps
`default_nettype none
`include "vocoder_stream_defs.vh"
module tb_top;
   logic        sys_clk;
   logic        rst;
   logic        ce;
   logic [15:0] analogIn;
   logic [15:0] r;
   wire         busSelN, busClk, busDataIn, busDataOut;
   wire  [15:0] audioOut, noiseLevel, biasCtrl, progValue;
   int          failures;
   int          totalChecks;
   int          cycles;
   vocoder_stream_transfer #(.SAMPLE_CYCLES(20), .PROC_CYCLES(8)) vocoder_stream_transfer_i (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .busSelN(busSelN), .busClk(busClk),
      .busDataIn(busDataIn), .busDataOut(busDataOut), .analogIn(analogIn),
      .audioOut(audioOut), .noiseLevel(noiseLevel), .biasCtrl(biasCtrl),
      .progValue(progValue));
   host_serial_model host_serial_model_i (
      .sys_clk(sys_clk), .busSelN(busSelN), .busClk(busClk),
      .busDataIn(busDataIn), .busDataOut(busDataOut));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ==========================================
   // helpers
   task automatic check(input string nm, input logic [15:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n, cnt);
      host_serial_model_i.xfer(a, d, n, cnt, r);
   endtask
   task automatic stat(input logic [15:0] e);
      host_serial_model_i.xfer(`ADDR_STATUS, 16'h0000, 16, 1, r);
      check("status", r, e);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // run is about 40k cycles; ceiling leaves margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         report_and_stop;
      end
   end
   // ==========================================
   // scenarios
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      analogIn = 16'h0123;
      failures = 0;
      totalChecks = 0;
      cycles = 0;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      stat(16'h0010);
      wr(`ADDR_IDLE_PROG, 16'h1234, 16, 1);
      check("prog", progValue, 16'h1234);
      wr(`ADDR_NOISE_LEVEL, 16'hA5C3, 16, 1);
      check("noise", noiseLevel, 16'hA5C3);
      wr(`ADDR_BIAS, 16'h0F0F, 16, 1);
      check("bias", biasCtrl, 16'h0F0F);
      ce = 1'b0;
      repeat (3) @(negedge sys_clk);
      ce = 1'b1;
      wr(`ADDR_ROUTING, 16'h0011, 16, 1);
      // encode: one frame of samples in one burst, codes read back singly
      wr(`ADDR_MODE_CONTROL, 16'h0002, 16, 1);
      stat(16'h4010);
      wr(`ADDR_IDLE_PROG, 16'h5555, 16, 1);
      check("prog", progValue, 16'h1234);
      wr(`ADDR_SAMPLE_IN, 16'h0100, 16, 160);
      stat(16'h4018);
      for (int i = 0; i < 9; i++) begin
         host_serial_model_i.xfer(`ADDR_CODED_OUT, 16'h0000, 8, 1, r);
         check("coded byte", {8'h00, r[7:0]}, {8'h00, 8'h9F ^ i[7:0]});
      end
      stat(16'h4010);
      // decode: partial packet holds off, then storage overruns
      wr(`ADDR_MODE_CONTROL, 16'h0001, 16, 1);
      wr(`ADDR_CODED_IN, 16'h0010, 8, 8);
      stat(16'h2010);
      wr(`ADDR_CODED_IN, 16'h0018, 8, 1);
      stat(16'h2018);
      wr(`ADDR_CODED_IN, 16'h0020, 8, 28);
      stat(16'h2028);
      wr(`ADDR_MODE_CONTROL, 16'h0000, 16, 1);
      stat(16'h0010);
      wr(`ADDR_CODED_IN, 16'h0030, 8, 9);
      stat(16'h0010);
      // analogue both ways in pass-through: audio is the held input xor index
      wr(`ADDR_ROUTING, 16'h0000, 16, 1);
      wr(`ADDR_MODE_CONTROL, 16'h0004, 16, 1);
      repeat (800) @(negedge sys_clk);
      check("audio", audioOut & 16'hFFF0, 16'h0120);
      stat(16'h8010);
      // bus in, speaker out: one packet plays out, then the path runs dry
      wr(`ADDR_ROUTING, 16'h0001, 16, 1);
      wr(`ADDR_MODE_CONTROL, 16'h0001, 16, 1);
      wr(`ADDR_CODED_IN, 16'h0030, 8, 9);
      repeat (4000) @(negedge sys_clk);
      stat(16'h2050);
      wr(`ADDR_ROUTING, 16'h0011, 16, 1);
      // every mode code lands in the status mode field with empty paths
      for (int m = 0; m < 6; m++) begin
         wr(`ADDR_MODE_CONTROL, {13'h0000, m[2:0]}, 16, 1);
         stat({m[2:0], 13'h0010});
      end
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire

// ---- tb/vocoder_stream_transfer_properties.sv ----
// checker for the vocoder streaming block: decodes host word writes
// off the serial pins and ties register outputs to them.
// assumes it sees only the top module's ports, bound below.
`timescale 1ns/1ps
`default_nettype none
`include "vocoder_stream_defs.vh"
module vocoder_stream_transfer_properties #(
   parameter SAMPLE_CYCLES = 5000,
   parameter PROC_CYCLES   = 64
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        busSelN,
   input wire logic        busClk,
   input wire logic        busDataIn,
   input wire logic        busDataOut,
   input wire logic [15:0] analogIn,
   input wire logic [15:0] audioOut,
   input wire logic [15:0] noiseLevel,
   input wire logic [15:0] biasCtrl,
   input wire logic [15:0] progValue
);
   // ==========================================
   // write decoder
   // every data phase taken as 16 bits: byte registers decode wrongly, unused here
   logic [2:0]  ck;
   logic [4:0]  cnt;
   logic [7:0]  adr;
   logic [15:0] sh;
   logic [15:0] wd;
   logic        done;
   logic [2:0]  md;
   logic        act;
   logic [3:0]  since;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ck    <= 3'h7;
         cnt   <= 5'h00;
         done  <= 1'b0;
         md    <= `MODE_IDLE;
         act   <= 1'b0;
         since <= 4'hF;
      end else if (ce) begin
         ck   <= {ck[1:0], busClk};
         done <= 1'b0;
         if (since != 4'hF) since <= since + 4'h1;
         if (done && adr == `ADDR_NOISE_LEVEL) since <= 4'h0;
         if (done && adr == `ADDR_MODE_CONTROL) begin
            md  <= wd[2:0];
            act <= act | (wd[2:0] != `MODE_IDLE);
         end
         if (busSelN) cnt <= 5'h00;
         else if (ck[1] && !ck[2]) begin
            sh   <= {sh[14:0], busDataIn};
            done <= (cnt == 5'h17);
            cnt  <= (cnt == 5'h17) ? 5'h08 : cnt + 5'h01;
            if (cnt == 5'h07) adr <= {sh[6:0], busDataIn};
            if (cnt == 5'h17) wd <= {sh[14:0], busDataIn};
         end
      end
   end
   // ==========================================
   // properties
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_zero_a: assert property (disable iff (1'b0) rst |-> audioOut == 16'h0000 &&
      busDataOut == 1'b0 && progValue == 16'h0000 && noiseLevel == 16'h0000)
      else $error("outputs not cleared in reset");
   noise_write_a: assert property (done && adr == `ADDR_NOISE_LEVEL |-> ##[1:8] noiseLevel == wd)
      else $error("noise level write not applied");
   bias_write_a: assert property (done && adr == `ADDR_BIAS |-> ##[1:8] biasCtrl == wd)
      else $error("bias write not applied");
   noise_quiet_a: assert property (!$stable(noiseLevel) |-> since < 4'hA)
      else $error("noise level moved without a write");
   prog_write_a: assert property (done && adr == `ADDR_IDLE_PROG && md == `MODE_IDLE
      |-> ##[1:8] progValue == wd) else $error("idle programming write lost");
   prog_refused_a: assert property (done && adr == `ADDR_IDLE_PROG && md != `MODE_IDLE
      |=> $stable(progValue)[*8]) else $error("programming write taken outside idle");
   quiet_idle_a: assert property (!act |-> audioOut == 16'h0000)
      else $error("audio moved before any active mode");
   freeze_hold_a: assert property (!ce |=> $stable(progValue) && $stable(noiseLevel) &&
      $stable(biasCtrl) && $stable(audioOut)) else $error("outputs moved while disabled");
endmodule // vocoder_stream_transfer_properties
bind vocoder_stream_transfer vocoder_stream_transfer_properties #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES), .PROC_CYCLES(PROC_CYCLES)) chk_i (
   .sys_clk(sys_clk), .rst(rst), .ce(ce), .busSelN(busSelN), .busClk(busClk),
   .busDataIn(busDataIn), .busDataOut(busDataOut), .analogIn(analogIn),
   .audioOut(audioOut), .noiseLevel(noiseLevel), .biasCtrl(biasCtrl),
   .progValue(progValue));
`default_nettype wire
